// file: logic/cis_top.sv
/*
 * CPU register file, stacking and interrupt sequencer with the
 * periodic interrupt counter and its control/status register.
 * Assumes the execution unit stalls while o_busy is high, memory
 * returns read data in the cycle after o_bus.re, and all inputs are
 * synchronous to i_mclk.
 */
// What this block does
// - Reset or stack reset loads top; push decrements, pull increments.
// - Stack address is fixed upper pattern plus six pointer bits; wraps.
// - Call uses two stack bytes; interrupt entry uses five.
// - Interrupt push order is low PC then high PC; pull reversed.
// - Eight-bit accumulator and index; five-bit flags H I N Z C.
// - Half carry changes only on add operations and on the flag pull of a return, carry from bit 3.
// - N and Z follow results; carry follows ALU, shifts, bit tests.
// - Program counter is thirteen bits, next fetch address.
// - Interrupt entry stacks context and sets mask; return restores it.
// - Hardware requests wait for the current instruction to complete.
// - Serve only when unmasked and enabled; masked requests stay latched.
// - External pin wins over timer when both pending.
// - Two-byte vectors at their fixed addresses per source.
// - Reset sets mask and loads start address from reset vector.
// - Software trap ignores mask; ordered after requests pending at fetch.
// - Stop turns oscillator off until pin request or reset.
// - Wait halts CPU clocks; exits on reset, pin, timer, periodic, serial or tw request.
// - Pin falling edge latched, synchronised, cleared early in service.
// - Pin trigger is level-and-edge or edge-only, chosen at build.
// - Timer request is either timer flag with its enable.
// - Periodic tick from slow oscillator via 15-bit counter, build period.
// - Periodic flag set on rollover; write zero clears; reset clears.
// - Periodic enable gates the request; reset clears it.
`timescale 1ns/100ps
module cis_top #(
   parameter bit IRQ_LEVEL = 1'b1,
   parameter int PER_QSEC = 1
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_arst_n,
   // Register port
   input wire cis_pkg::cis_regreq_s i_reg,
   output logic [7:0] o_reg_rdata,
   // Execution unit
   input wire cis_pkg::cis_exec_s i_exec,
   output logic o_busy,
   output logic [7:0] o_acc,
   output logic [7:0] o_idx,
   output cis_pkg::cis_flags_s o_flags,
   output logic [12:0] o_pc,
   output logic [5:0] o_sp,
   // Memory bus
   output cis_pkg::cis_bus_s o_bus,
   input wire logic [7:0] i_mem_rdata,
   // Interrupt sources and power control
   input wire logic i_irq_n,
   input wire logic i_low_freq_osc_input,
   input wire cis_pkg::cis_src_s i_src,
   output logic o_osc_off,
   output logic o_cpu_clk_halt
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   localparam logic [14:0] PER_STEP =
      15'(cis_pkg::PER_FULL_QSEC / PER_QSEC);

   cis_pkg::cis_state_e state_reg, state_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [2:0] last_reg, last_next;
   logic [12:0] vec_reg, vec_next;
   logic int_reg, int_next;
   logic swi_pend_reg, swi_pend_next;
   logic fetch_pend_reg, fetch_pend_next;
   cis_pkg::cis_bus_s bus_next;
   cis_pkg::cis_tag_s tag1_reg, tag2_reg, tag_next;
   logic [5:0] sp_reg, sp_next;
   logic [12:0] pc_reg, pc_next;
   logic [7:0] acc_reg, acc_next, idx_reg, idx_next, vhi_reg, vhi_next;
   cis_pkg::cis_flags_s flags_reg, flags_next;
   logic set_mask;
   logic take_pin;
   logic irq_s1_reg, irq_s2_reg, irq_s3_reg, pin_latch_reg, pin_latch_next;
   logic lf_d_reg;
   logic [14:0] per_cnt_reg, per_cnt_next;
   logic per_flag_reg, per_flag_next, per_en_reg, per_en_next;
   logic [7:0] rdata_next;
   logic busy_next, osc_off_next, halt_next;

   // Stack address from the fixed page and the pointer
   function automatic logic [12:0] stack_addr(input logic [5:0] sp);
      stack_addr = {cis_pkg::STACK_PAGE, sp};
   endfunction

   // Highest priority enabled source, pin first
   function automatic logic [12:0] pick_vec(input logic [4:0] req);
      if (req[0]) begin
         pick_vec = cis_pkg::VEC_PIN;
      end else if (req[1]) begin
         pick_vec = cis_pkg::VEC_TMR;
      end else if (req[2]) begin
         pick_vec = cis_pkg::VEC_PER;
      end else if (req[3]) begin
         pick_vec = cis_pkg::VEC_SER;
      end else begin
         pick_vec = cis_pkg::VEC_TW;
      end
   endfunction

   // ---------------------------------------------------------------
   // Request decoding
   // ---------------------------------------------------------------
   // Pin edge detect reads only the synchronised stages
   wire pin_fall = irq_s3_reg & ~irq_s2_reg;
   wire pin_req = pin_latch_reg | (IRQ_LEVEL & ~irq_s2_reg);
   wire tmr_req = (i_src.timer_overflow_flag & i_src.tofe)
      | (i_src.realtime_tick_flag & i_src.rtie);
   wire per_req = per_flag_reg & per_en_reg;
   wire ser_req = i_src.ser_flag & i_src.ser_en;
   wire tw_req = i_src.tw_flag & i_src.tw_en;
   wire [4:0] hw_raw = {tw_req, ser_req, per_req, tmr_req, pin_req};
   wire hw_go = (|hw_raw) & ~flags_reg.i;
   wire [12:0] hw_vec = pick_vec(hw_raw);
   wire hw_is_pin = pin_req;
   wire wait_wake = pin_req | tmr_req | per_req | ser_req | tw_req;
   // Software trap yields only to requests already pending at its fetch
   wire swi_first = i_exec.software_trap_instr & ~fetch_pend_reg;

   // Register port decode
   wire csr_hit = (i_reg.addr == cis_pkg::PER_CSR_OFS);
   wire csr_wr = i_reg.wr & csr_hit;
   wire flag_clr = csr_wr & ~i_reg.wdata[cis_pkg::PER_FLAG_POS];

   // Periodic counter runs on slow oscillator rising edges
   wire lf_rise = i_low_freq_osc_input & ~lf_d_reg;
   wire per_run = lf_rise & (state_reg != cis_pkg::ST_STOP);
   wire [15:0] per_sum = {1'b0, per_cnt_reg} + {1'b0, PER_STEP};
   wire per_roll = per_run & per_sum[15];

   // Stacked byte for the current push index
   wire [7:0] flg_byte = {cis_pkg::FLG_PAD, flags_reg};
   wire [7:0] push_byte = (cnt_reg == 3'h0) ? pc_reg[7:0] :
      (cnt_reg == 3'h1) ? {3'h0, pc_reg[12:8]} :
      (cnt_reg == 3'h2) ? idx_reg :
      (cnt_reg == 3'h3) ? acc_reg : flg_byte;
   wire [5:0] sp_dec = 6'(sp_reg - 6'h01);
   wire [5:0] sp_inc = 6'(sp_reg + 6'h01);

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Instruction boundary decisions and stack/vector walks
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      last_next = last_reg;
      vec_next = vec_reg;
      int_next = int_reg;
      swi_pend_next = swi_pend_reg;
      bus_next = '0;
      tag_next = '0;
      sp_next = sp_reg;
      set_mask = 1'b0;
      take_pin = 1'b0;
      case (state_reg)
         cis_pkg::ST_RUN: begin
            if (i_exec.instr_done) begin
               if (i_exec.rsp) begin
                  sp_next = cis_pkg::SP_TOP;
               end
               if (i_exec.software_trap_instr && (swi_first || flags_reg.i)) begin
                  state_next = cis_pkg::ST_PUSH;
                  cnt_next = 3'h0;
                  last_next = cis_pkg::LAST_INT;
                  int_next = 1'b1;
                  vec_next = cis_pkg::VEC_SWI;
               end else if (hw_go) begin
                  state_next = cis_pkg::ST_PUSH;
                  cnt_next = 3'h0;
                  last_next = cis_pkg::LAST_INT;
                  int_next = 1'b1;
                  vec_next = hw_vec;
                  take_pin = hw_is_pin;
                  swi_pend_next = i_exec.software_trap_instr;
               end else if (i_exec.return_from_service_instr) begin
                  state_next = cis_pkg::ST_PULL;
                  cnt_next = cis_pkg::LAST_INT;
               end else if (i_exec.call) begin
                  state_next = cis_pkg::ST_PUSH;
                  cnt_next = 3'h0;
                  last_next = cis_pkg::LAST_CALL;
                  int_next = 1'b0;
               end else if (i_exec.ret) begin
                  state_next = cis_pkg::ST_PULL;
                  cnt_next = cis_pkg::LAST_CALL;
               end else if (i_exec.stop) begin
                  state_next = cis_pkg::ST_STOP;
               end else if (i_exec.wait_op) begin
                  state_next = cis_pkg::ST_WAIT;
               end
            end
         end
         cis_pkg::ST_PUSH: begin
            bus_next.addr = stack_addr(sp_reg);
            bus_next.wdata = push_byte;
            bus_next.we = 1'b1;
            sp_next = sp_dec;
            if (cnt_reg == last_reg) begin
               cnt_next = 3'h0;
               if (int_reg) begin
                  set_mask = 1'b1;
                  state_next = cis_pkg::ST_VEC;
               end else begin
                  state_next = cis_pkg::ST_RUN;
               end
            end else begin
               cnt_next = 3'(cnt_reg + 3'h1);
            end
         end
         cis_pkg::ST_PULL: begin
            // Pointer moves up before the read, reverse of the push
            bus_next.addr = stack_addr(sp_inc);
            bus_next.re = 1'b1;
            tag_next = '{v: 1'b1, tgt: cis_pkg::cis_ld_e'(cnt_reg)};
            sp_next = sp_inc;
            if (cnt_reg == 3'h0) begin
               state_next = cis_pkg::ST_DRAIN;
            end else begin
               cnt_next = 3'(cnt_reg - 3'h1);
            end
         end
         cis_pkg::ST_VEC: begin
            bus_next.addr = 13'(vec_reg + {10'h0, cnt_reg});
            bus_next.re = 1'b1;
            tag_next.v = 1'b1;
            tag_next.tgt = (cnt_reg == 3'h0) ? cis_pkg::LD_VHI :
               cis_pkg::LD_VLO;
            if (cnt_reg == 3'h0) begin
               cnt_next = 3'h1;
            end else begin
               state_next = cis_pkg::ST_DRAIN;
            end
         end
         cis_pkg::ST_DRAIN: begin
            // Deferred software trap enters once the vector landed
            if (!tag1_reg.v && !tag2_reg.v) begin
               if (swi_pend_reg) begin
                  swi_pend_next = 1'b0;
                  state_next = cis_pkg::ST_PUSH;
                  cnt_next = 3'h0;
                  last_next = cis_pkg::LAST_INT;
                  int_next = 1'b1;
                  vec_next = cis_pkg::VEC_SWI;
               end else begin
                  state_next = cis_pkg::ST_RUN;
               end
            end
         end
         cis_pkg::ST_STOP: begin
            if (pin_req) begin
               state_next = cis_pkg::ST_RUN;
               if (hw_go) begin
                  state_next = cis_pkg::ST_PUSH;
                  cnt_next = 3'h0;
                  last_next = cis_pkg::LAST_INT;
                  int_next = 1'b1;
                  vec_next = cis_pkg::VEC_PIN;
                  take_pin = 1'b1;
               end
            end
         end
         cis_pkg::ST_WAIT: begin
            // No dedicated wake vectors: the normal ones are used
            if (wait_wake) begin
               state_next = cis_pkg::ST_RUN;
               if (hw_go) begin
                  state_next = cis_pkg::ST_PUSH;
                  cnt_next = 3'h0;
                  last_next = cis_pkg::LAST_INT;
                  int_next = 1'b1;
                  vec_next = hw_vec;
                  take_pin = hw_is_pin;
               end
            end
         end
         default: begin
            state_next = cis_pkg::ST_RUN;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Datapath registers
   // ---------------------------------------------------------------
   // Pull data lands two cycles after the read was issued
   always_comb begin
      pc_next = pc_reg;
      acc_next = acc_reg;
      idx_next = idx_reg;
      vhi_next = vhi_reg;
      flags_next = flags_reg;
      if (state_reg == cis_pkg::ST_RUN) begin
         if (i_exec.acc_we) begin
            acc_next = i_exec.acc_d;
         end
         if (i_exec.idx_we) begin
            idx_next = i_exec.idx_d;
         end
         if (i_exec.pc_we) begin
            pc_next = i_exec.pc_d;
         end else if (i_exec.pc_inc) begin
            pc_next = 13'(pc_reg + 13'h0001);
         end
         if (i_exec.add_op) begin
            flags_next.h = i_exec.h;
         end
         if (i_exec.nz_we) begin
            flags_next.n = i_exec.n;
            flags_next.z = i_exec.z;
         end
         if (i_exec.c_we) begin
            flags_next.c = i_exec.c;
         end
         if (i_exec.sei) begin
            flags_next.i = 1'b1;
         end else if (i_exec.cli) begin
            flags_next.i = 1'b0;
         end
      end
      if (tag2_reg.v) begin
         case (tag2_reg.tgt)
            cis_pkg::LD_PCL: pc_next[7:0] = i_mem_rdata;
            cis_pkg::LD_PCH: pc_next[12:8] = i_mem_rdata[4:0];
            cis_pkg::LD_IDX: idx_next = i_mem_rdata;
            cis_pkg::LD_ACC: acc_next = i_mem_rdata;
            cis_pkg::LD_FLG: flags_next = i_mem_rdata[4:0];
            cis_pkg::LD_VHI: vhi_next = i_mem_rdata;
            default: pc_next = {vhi_reg[4:0], i_mem_rdata};
         endcase
      end
      if (set_mask) begin
         flags_next.i = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Sources and periodic register
   // ---------------------------------------------------------------
   // Rollover and edge win over a clear in the same cycle
   assign pin_latch_next = pin_fall | (pin_latch_reg & ~take_pin);
   assign per_cnt_next = per_run ? per_sum[14:0] : per_cnt_reg;
   assign per_flag_next = per_roll | (per_flag_reg & ~flag_clr);
   assign per_en_next = csr_wr ? i_reg.wdata[cis_pkg::PER_EN_POS] :
      per_en_reg;
   assign fetch_pend_next = i_exec.fetch ? hw_go : fetch_pend_reg;

   // Read data stand for one cycle only, unmapped reads give zero
   always_comb begin
      rdata_next = 8'h00;
      if (i_reg.rd && csr_hit) begin
         rdata_next[cis_pkg::PER_FLAG_POS] = per_flag_reg;
         rdata_next[cis_pkg::PER_EN_POS] = per_en_reg;
      end
   end

   assign busy_next = (state_next != cis_pkg::ST_RUN);
   assign osc_off_next = (state_next == cis_pkg::ST_STOP);
   assign halt_next = (state_next == cis_pkg::ST_WAIT)
      | (state_next == cis_pkg::ST_STOP);

   // ---------------------------------------------------------------
   // Flip-flops
   // ---------------------------------------------------------------
   // Reset walks straight into the reset vector fetch with mask set
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_reg <= cis_pkg::ST_VEC;
         cnt_reg <= 3'h0;
         last_reg <= 3'h0;
         vec_reg <= cis_pkg::VEC_RESET;
         int_reg <= 1'b0;
         swi_pend_reg <= 1'b0;
         fetch_pend_reg <= 1'b0;
         tag1_reg <= '0;
         tag2_reg <= '0;
         sp_reg <= cis_pkg::SP_TOP;
         o_bus <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         last_reg <= last_next;
         vec_reg <= vec_next;
         int_reg <= int_next;
         swi_pend_reg <= swi_pend_next;
         fetch_pend_reg <= fetch_pend_next;
         tag1_reg <= tag_next;
         tag2_reg <= tag1_reg;
         sp_reg <= sp_next;
         o_bus <= bus_next;
      end
   end

   // Programming model
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pc_reg <= 13'h0000;
         acc_reg <= 8'h00;
         idx_reg <= 8'h00;
         vhi_reg <= 8'h00;
         flags_reg <= 5'h08;
      end else begin
         pc_reg <= pc_next;
         acc_reg <= acc_next;
         idx_reg <= idx_next;
         vhi_reg <= vhi_next;
         flags_reg <= flags_next;
      end
   end

   // Pin synchroniser, periodic unit and outputs
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_s1_reg <= 1'b1;
         irq_s2_reg <= 1'b1;
         irq_s3_reg <= 1'b1;
         pin_latch_reg <= 1'b0;
         lf_d_reg <= 1'b0;
         per_cnt_reg <= 15'h0000;
         per_flag_reg <= cis_pkg::PER_FLAG_RST;
         per_en_reg <= cis_pkg::PER_EN_RST;
         o_reg_rdata <= 8'h00;
         o_busy <= 1'b1;
         o_osc_off <= 1'b0;
         o_cpu_clk_halt <= 1'b0;
      end else begin
         irq_s1_reg <= i_irq_n;
         irq_s2_reg <= irq_s1_reg;
         irq_s3_reg <= irq_s2_reg;
         pin_latch_reg <= pin_latch_next;
         lf_d_reg <= i_low_freq_osc_input;
         per_cnt_reg <= per_cnt_next;
         per_flag_reg <= per_flag_next;
         per_en_reg <= per_en_next;
         o_reg_rdata <= rdata_next;
         o_busy <= busy_next;
         o_osc_off <= osc_off_next;
         o_cpu_clk_halt <= halt_next;
      end
   end

   assign o_acc = acc_reg;
   assign o_idx = idx_reg;
   assign o_flags = flags_reg;
   assign o_pc = pc_reg;
   assign o_sp = sp_reg;

endmodule

// file: logic/cis_pkg.sv
/*
 * Shared constants and carrier types for the CPU interrupt sequencer.
 * Assumes an 8-bit data path, a 13-bit code address space and a
 * synchronous single-clock system around the block.
 */
package cis_pkg;

   // ---------------------------------------------------------------
   // Register map of the periodic interrupt unit
   // ---------------------------------------------------------------
   localparam logic [7:0] PER_CSR_OFS = 8'h12;
   localparam int PER_FLAG_POS = 6;
   localparam int PER_EN_POS = 4;
   localparam logic PER_FLAG_RST = 1'b0;
   localparam logic PER_EN_RST = 1'b0;
   localparam logic [14:0] PER_LAST = 15'h7fff;
   // Quarter seconds in one full wrap at a step of one
   localparam int PER_FULL_QSEC = 4;

   // ---------------------------------------------------------------
   // Stack and program counter
   // ---------------------------------------------------------------
   localparam logic [5:0] SP_TOP = 6'h3f;
   localparam logic [6:0] STACK_PAGE = 7'h03;
   localparam logic [2:0] LAST_INT = 3'h4;
   localparam logic [2:0] LAST_CALL = 3'h1;
   localparam logic [2:0] FLG_PAD = 3'h7;

   // ---------------------------------------------------------------
   // Vector addresses, high byte first, low byte at the next address
   // ---------------------------------------------------------------
   localparam logic [12:0] VEC_RESET = 13'h1ffe;
   localparam logic [12:0] VEC_SWI = 13'h1ffc;
   localparam logic [12:0] VEC_PIN = 13'h1ffa;
   localparam logic [12:0] VEC_TMR = 13'h1ff8;
   localparam logic [12:0] VEC_PER = 13'h1ff6;
   localparam logic [12:0] VEC_SER = 13'h1ff4;
   localparam logic [12:0] VEC_TW = 13'h1ff2;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RUN, ST_PUSH, ST_PULL, ST_VEC, ST_DRAIN, ST_STOP, ST_WAIT
   } cis_state_e;

   // Pull targets; the first five follow the stacking index
   typedef enum logic [2:0] {
      LD_PCL, LD_PCH, LD_IDX, LD_ACC, LD_FLG, LD_VHI, LD_VLO
   } cis_ld_e;

   typedef struct packed {
      logic h;
      logic i;
      logic n;
      logic z;
      logic c;
   } cis_flags_s;

   typedef struct packed {
      logic [12:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } cis_bus_s;

   typedef struct packed {
      logic v;
      cis_ld_e tgt;
   } cis_tag_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cis_regreq_s;

   typedef struct packed {
      logic timer_overflow_flag;
      logic tofe;
      logic realtime_tick_flag;
      logic rtie;
      logic ser_flag;
      logic ser_en;
      logic tw_flag;
      logic tw_en;
   } cis_src_s;

   typedef struct packed {
      logic fetch;
      logic instr_done;
      logic software_trap_instr;
      logic return_from_service_instr;
      logic call;
      logic ret;
      logic stop;
      logic wait_op;
      logic rsp;
      logic sei;
      logic cli;
      logic acc_we;
      logic [7:0] acc_d;
      logic idx_we;
      logic [7:0] idx_d;
      logic pc_we;
      logic [12:0] pc_d;
      logic pc_inc;
      logic add_op;
      logic h;
      logic nz_we;
      logic n;
      logic z;
      logic c_we;
      logic c;
   } cis_exec_s;

endpackage

// file: bench/cis_mem_model.sv
/*
 Memory partner: byte store with vector table contents.
 Assumes one request per cycle on the design's memory bus.
*/
`timescale 1ns/100ps
module cis_mem_model (
   // Clock and bus
   input wire logic i_mclk,
   input wire cis_pkg::cis_bus_s i_bus,
   // Read data
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:8191];
   // ------------------------------------------------
   // Storage
   // ------------------------------------------------
   // Every byte holds its low address bits xor 3c
   initial begin
      for (int a = 0; a < 8192; a++) begin
         mem[a] = a[7:0] ^ 8'h3c;
      end
      o_rdata = 8'h00;
   end
   // Idle data toggle so a stale byte is never seen as valid
   always @(posedge i_mclk) begin
      if (i_bus.we) begin
         mem[i_bus.addr] <= i_bus.wdata;
      end
      o_rdata <= i_bus.re ? mem[i_bus.addr] : ~o_rdata;
   end
endmodule

// file: bench/cis_top_checker.sv
/*
 Port checker for the sequencer top.
 Assumes binding to cis_top, one clock domain.
*/
`timescale 1ns/100ps
module cis_top_checker (
   // Clock, reset, register port
   input wire logic i_mclk,
   input wire logic i_arst_n,
   input wire cis_pkg::cis_regreq_s i_reg,
   input wire logic [7:0] o_reg_rdata,
   // Execution side
   input wire cis_pkg::cis_exec_s i_exec,
   input wire logic o_busy,
   input wire cis_pkg::cis_flags_s o_flags,
   input wire cis_pkg::cis_bus_s o_bus,
   // Pin and power
   input wire logic i_irq_n,
   input wire logic o_osc_off,
   input wire logic o_cpu_clk_halt
);
   // ------------------------------------------------
   // Properties
   // ------------------------------------------------
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   // Five back to back writes only occur on entry
   sequence s_entry;
      o_bus.we [*5];
   endsequence
   AST_STK_PAGE: assert property (o_bus.we |->
      o_bus.addr[12:6] == 7'h03) else $error("stack page wrong");
   AST_PUSH_DOWN: assert property (o_bus.we ##1 o_bus.we |->
      o_bus.addr[5:0] == 6'($past(o_bus.addr[5:0]) - 6'h01))
      else $error("push not descending");
   AST_MASK_SET: assert property (s_entry |-> ##[0:4] o_flags.i)
      else $error("mask not set on entry");
   AST_VEC_READ: assert property (s_entry ##1 o_bus.re |->
      o_bus.addr[12:4] == 9'h1ff && !o_bus.addr[0])
      else $error("vector fetch address wrong");
   AST_RD_FIELDS: assert property (i_reg.rd |=>
      (o_reg_rdata & 8'haf) == 8'h00) else $error("unused bits set");
   AST_RD_UNMAP: assert property (i_reg.rd && i_reg.addr != 8'h12
      |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
   AST_STOP_HALT: assert property (o_osc_off |-> o_cpu_clk_halt)
      else $error("stop without clock halt");
   AST_STOP_WAKE: assert property (o_osc_off && $fell(i_irq_n)
      |-> ##[1:10] !o_osc_off) else $error("no wake on pin");
   AST_NO_ABORT: assert property ($rose(o_busy) |->
      $past(i_exec.instr_done)) else $error("entry off boundary");
endmodule

// file: bench/cis_top_tb_top.sv
/*
 Directed bench for the sequencer top.
 Assumes the memory partner model and the checker.
*/
`timescale 1ns/100ps
module cis_top_tb_top;
   logic i_mclk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_irq_n = 1'b1;
   logic osc = 1'b0;
   logic osc_run = 1'b0;
   cis_pkg::cis_regreq_s reg_r = '0;
   cis_pkg::cis_exec_s ex_r = '0;
   cis_pkg::cis_src_s src_r = '0;
   cis_pkg::cis_bus_s bus;
   cis_pkg::cis_flags_s flags;
   logic [7:0] rdata, mdata, acc, idx;
   logic [12:0] pc;
   logic [5:0] sp;
   logic busy, osc_off, halt;
   int fails = 0;
   int num_checks = 0;
   // ------------------------------------------------
   // Clocks and instances
   // ------------------------------------------------
   always #50 i_mclk = ~i_mclk;
   // Slow clock is four fast cycles, keeps the run short
   always begin
      repeat (2) @(posedge i_mclk);
      if (osc_run) osc <= ~osc;
   end
   cis_top #(.IRQ_LEVEL(1'b1), .PER_QSEC(1)) dut_u (.i_mclk(i_mclk),
      .i_arst_n(i_arst_n), .i_reg(reg_r), .o_reg_rdata(rdata),
      .i_exec(ex_r), .o_busy(busy), .o_acc(acc), .o_idx(idx),
      .o_flags(flags), .o_pc(pc), .o_sp(sp), .o_bus(bus),
      .i_mem_rdata(mdata), .i_irq_n(i_irq_n),
      .i_low_freq_osc_input(osc), .i_src(src_r),
      .o_osc_off(osc_off), .o_cpu_clk_halt(halt));
   cis_mem_model mem_u (.i_mclk(i_mclk), .i_bus(bus), .o_rdata(mdata));
   // ------------------------------------------------
   // Tasks
   // ------------------------------------------------
   function automatic logic [12:0] pcv(input logic [12:0] v);
      logic [7:0] hi;
      hi = v[7:0] ^ 8'h3c;
      return {hi[4:0], (v[7:0] + 8'h1) ^ 8'h3c};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (fails == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic idle;
      repeat (3) @(posedge i_mclk);
      #1;
      for (int n = 0; n < 60 && busy; n++) @(posedge i_mclk) #1;
      chk(busy, 0);
   endtask
   // Op 0 end, 1 return, 2 stop, 3 sei, 4 cli, 5 data, 6 trap, 7 call, 8 wait
   task automatic ex(input int op, input logic [7:0] d);
      cis_pkg::cis_exec_s v;
      v = '0;
      v.instr_done = (op < 3) || (op > 5);
      v.return_from_service_instr = (op == 1);
      v.stop = (op == 2);
      v.sei = (op == 3);
      v.cli = (op == 4);
      v.acc_we = (op == 5);
      v.acc_d = d;
      v.idx_we = (op == 5);
      v.idx_d = ~d;
      v.software_trap_instr = (op == 6);
      v.call = (op == 7);
      v.wait_op = (op == 8);
      @(posedge i_mclk) ex_r <= v;
      @(posedge i_mclk) ex_r <= '0;
      if (op != 2 && op != 8) idle;
   endtask
   task automatic pin;
      @(posedge i_mclk) i_irq_n <= 1'b0;
      repeat (6) @(posedge i_mclk);
      i_irq_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk) reg_r <= '{a, d, 1'b1, 1'b0};
      @(posedge i_mclk) reg_r <= '0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_mclk) reg_r <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge i_mclk) reg_r <= '0;
      #1 chk(rdata, e);
   endtask
   // ------------------------------------------------
   // Main sequence
   // ------------------------------------------------
   initial begin
      repeat (6) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      idle;
      chk(pc, pcv(13'h1ffe));
      chk(flags.i, 1);
      chk(sp, 6'h3f);
      reg_rd(8'h12, 8'h00);
      reg_wr(8'h12, 8'hff);
      reg_rd(8'h12, 8'h10);
      reg_wr(8'h13, 8'hff);
      reg_rd(8'h13, 8'h00);
      ex(5, 8'ha5);
      ex(4, 8'h00);
      pin;
      ex(0, 8'h00);
      chk(pc, pcv(13'h1ffa));
      chk(sp, 6'h3a);
      chk(flags.i, 1);
      ex(5, 8'h00);
      ex(1, 8'h00);
      chk(acc, 8'ha5);
      chk(idx, 8'h5a);
      chk(pc, pcv(13'h1ffe));
      chk(sp, 6'h3f);
      chk(flags.i, 0);
      ex(3, 8'h00);
      @(posedge i_mclk) src_r <= 8'hc0;
      pin;
      ex(0, 8'h00);
      chk(pc, pcv(13'h1ffe));
      ex(4, 8'h00);
      ex(0, 8'h00);
      chk(pc, pcv(13'h1ffa));
      ex(1, 8'h00);
      ex(0, 8'h00);
      chk(pc, pcv(13'h1ff8));
      @(posedge i_mclk) src_r <= '0;
      ex(1, 8'h00);
      osc_run <= 1'b1;
      repeat (33000) @(posedge i_mclk);
      osc_run <= 1'b0;
      reg_rd(8'h12, 8'h50);
      ex(0, 8'h00);
      chk(pc, pcv(13'h1ff6));
      reg_wr(8'h12, 8'h10);
      reg_rd(8'h12, 8'h10);
      ex(6, 8'h00);
      chk(pc, pcv(13'h1ffc));
      chk(sp, 6'h35);
      ex(1, 8'h00);
      ex(7, 8'h00);
      chk(sp, 6'h38);
      ex(8, 8'h00);
      #1 chk(halt, 1);
      @(posedge i_mclk) src_r <= 8'hc0;
      idle;
      chk(halt, 0);
      @(posedge i_mclk) src_r <= '0;
      ex(3, 8'h00);
      ex(2, 8'h00);
      repeat (3) @(posedge i_mclk);
      #1 chk(osc_off, 1);
      chk(halt, 1);
      pin;
      idle;
      chk(osc_off, 0);
      test_done;
   end
   // Watchdog well beyond the expected run length
   initial begin
      #8000000;
      fails++;
      test_done;
   end
endmodule
bind cis_top cis_top_checker chk_u (.*);
